// >>> src/dpr_pkg.sv
package dpr_pkg;

  // ************************************************************
  // Bank geometry and register indices
  // ************************************************************
  localparam int NPROF = 2;
  localparam int NREG = 13;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_B_PRIORITY_ENABLE = 12'h44d;
  localparam logic [IDX_W-1:0] IDX_B_BW_SCALE_LOW = 12'h44e;
  localparam logic [IDX_W-1:0] IDX_B_BW_SCALE_MID = 12'h44f;
  localparam logic [IDX_W-1:0] IDX_B_BW_TOP_FILTER_SEL = 12'h450;
  localparam logic [IDX_W-1:0] IDX_B_INT_DIV_LOW = 12'h451;
  localparam logic [IDX_W-1:0] IDX_B_INT_DIV_MID = 12'h452;
  localparam logic [IDX_W-1:0] IDX_B_INT_DIV_HIGH = 12'h453;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_NUM_LOW = 12'h454;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_NUM_MID = 12'h455;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_NUM_HIGH = 12'h456;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_DEN_LOW = 12'h457;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_DEN_MID = 12'h458;
  localparam logic [IDX_W-1:0] IDX_B_FRAC_DEN_HIGH = 12'h459;
  localparam logic [IDX_W-1:0] IDX_C_PRIORITY_ENABLE = 12'h45a;
  localparam logic [IDX_W-1:0] IDX_STATUS = 12'h4f0;

  // Offsets of each register inside one profile
  localparam logic [3:0] REL_PRIO = 4'h0;
  localparam logic [3:0] REL_BW_LOW = 4'h1;
  localparam logic [3:0] REL_BW_MID = 4'h2;
  localparam logic [3:0] REL_BW_TOP = 4'h3;
  localparam logic [3:0] REL_INT_LOW = 4'h4;
  localparam logic [3:0] REL_INT_MID = 4'h5;
  localparam logic [3:0] REL_INT_HIGH = 4'h6;
  localparam logic [3:0] REL_NUM_LOW = 4'h7;
  localparam logic [3:0] REL_NUM_MID = 4'h8;
  localparam logic [3:0] REL_NUM_HIGH = 4'h9;
  localparam logic [3:0] REL_DEN_LOW = 4'ha;
  localparam logic [3:0] REL_DEN_MID = 4'hb;
  localparam logic [3:0] REL_DEN_HIGH = 4'hc;

  // ************************************************************
  // Field layout, writable masks and reset values
  // ************************************************************
  localparam int PRIO_EN_BIT = 0;
  localparam int PRIO_LSB = 1;
  localparam int TOP_BW16_BIT = 0;
  localparam int TOP_FILT_BIT = 1;
  localparam logic [7:0] MASK_PRIO = 8'h07;
  localparam logic [7:0] MASK_TWO = 8'h03;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } dpr_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } dpr_axil_rsp_t;

  typedef struct packed {
    logic enable;
    logic [1:0] priority_level;
    logic [16:0] bw_scale;
    logic high_margin;
    logic [17:0] int_div_m1;
    logic [23:0] frac_num;
    logic [23:0] frac_den;
  } dpr_profile_t;

  typedef struct packed {
    logic hit;
    logic status;
    logic prof;
    logic [3:0] rel;
  } dpr_decode_t;

endpackage

// >>> src/dpr_reference_profile_regs.sv
// Contract
// - Each profile holds a two-bit priority at bits 2:1, code 00 highest.
// - Priority register bit 0 makes the input eligible when 1, excluded when 0.
// - Bandwidth factor is 17 bits in 0.1 Hz, bit 16 in third byte bit 0.
// - Third bandwidth byte bit 1 selects normal or high phase margin filter.
// - Integer divider is 18 bits over three bytes, ratio is stored value plus one.
// - Fraction numerator is 24 bits over three bytes, low byte at lowest address.
// - Fraction modulus is 24 bits over three bytes, low byte at lowest address.
// - After reset every profile field is zero.
// - A zero modulus disables and bypasses the fractional divider.
module dpr_reference_profile_regs (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire dpr_pkg::dpr_axil_req_t axi_req,
  output dpr_pkg::dpr_axil_rsp_t axi_rsp,
  output dpr_pkg::dpr_profile_t active_cfg,
  output logic active_valid,
  output logic active_ref,
  output logic [18:0] active_div_ratio,
  output logic active_frac_enable
);
  import dpr_pkg::*;

  // ************************************************************
  // Address decoding
  // ************************************************************

  // Shared by the write and read paths; misaligned or out-of-bank words miss
  function automatic dpr_decode_t decode(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    dpr_decode_t d;
    idx = addr[IDX_W+1:2];
    d = '0;
    if (addr[1:0] == 2'h0 && addr[ADDR_W-1:IDX_W+2] == '0) begin
      if (idx >= IDX_B_PRIORITY_ENABLE && idx <= IDX_B_FRAC_DEN_HIGH) begin
        d.hit = 1'b1;
        d.rel = 4'(idx - IDX_B_PRIORITY_ENABLE);
      end else if (idx >= IDX_C_PRIORITY_ENABLE && idx < IDX_C_PRIORITY_ENABLE + 12'(NREG)) begin
        d.hit = 1'b1;
        d.prof = 1'b1;
        d.rel = 4'(idx - IDX_C_PRIORITY_ENABLE);
      end else if (idx == IDX_STATUS) begin
        d.hit = 1'b1;
        d.status = 1'b1;
      end
    end
    return d;
  endfunction

  // Writable bits of each register inside a profile
  function automatic logic [7:0] wmask(input logic [3:0] rel);
    logic [7:0] m;
    case (rel)
      REL_PRIO: m = MASK_PRIO;
      REL_BW_TOP, REL_INT_HIGH: m = MASK_TWO;
      default: m = MASK_FULL;
    endcase
    return m;
  endfunction

  // ************************************************************
  // Storage and AXI4-Lite slave
  // ************************************************************
  logic [7:0] bank_q [NPROF][NREG];
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] status_byte;
  logic aw_take, w_take, ar_take, wr_go;
  dpr_decode_t wdec, rdec;

  // Address and data are taken in either order and held until both are here
  assign aw_take = clk_en && axi_req.awvalid && !aw_held_q && !bvalid_q;
  assign w_take = clk_en && axi_req.wvalid && !w_held_q && !bvalid_q;
  assign wr_go = clk_en && aw_held_q && w_held_q && !bvalid_q;
  assign ar_take = clk_en && axi_req.arvalid && !rvalid_q;
  assign wdec = decode(aw_addr_q);
  assign rdec = decode(axi_req.araddr);

  // Write address holding
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= axi_req.awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      wdata_q <= axi_req.wdata;
      wstrb_q <= axi_req.wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // Profile bytes; only lane 0 carries data, masked so reserved bits stay zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < NPROF; p++) begin
        for (int r = 0; r < NREG; r++) begin
          bank_q[p][r] <= RESET_BYTE;
        end
      end
    end else if (wr_go && wdec.hit && !wdec.status && wstrb_q[0]) begin
      bank_q[wdec.prof][wdec.rel] <= wdata_q[7:0] & wmask(wdec.rel);
    end
  end

  // Write response; status is read-only and silently ignores writes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (clk_en && axi_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel, data registered one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
      if (!rdec.hit) begin
        rdata_q <= '0;
      end else if (rdec.status) begin
        rdata_q <= {24'h000000, status_byte};
      end else begin
        rdata_q <= {24'h000000, bank_q[rdec.prof][rdec.rel]};
      end
    end else if (clk_en && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = clk_en && !aw_held_q && !bvalid_q;
    axi_rsp.wready = clk_en && !w_held_q && !bvalid_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = clk_en && !rvalid_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
  end

  // ************************************************************
  // Field assembly and reference selection
  // ************************************************************
  dpr_profile_t prof [NPROF];

  // Each profile's bytes gathered into its fields, low byte at lowest index
  for (genvar p = 0; p < NPROF; p++) begin : g_prof
    assign prof[p].enable = bank_q[p][REL_PRIO][PRIO_EN_BIT];
    assign prof[p].priority_level = bank_q[p][REL_PRIO][PRIO_LSB+1:PRIO_LSB];
    assign prof[p].bw_scale = {bank_q[p][REL_BW_TOP][TOP_BW16_BIT], bank_q[p][REL_BW_MID],
                               bank_q[p][REL_BW_LOW]};
    assign prof[p].high_margin = bank_q[p][REL_BW_TOP][TOP_FILT_BIT];
    assign prof[p].int_div_m1 = {bank_q[p][REL_INT_HIGH][1:0], bank_q[p][REL_INT_MID],
                                 bank_q[p][REL_INT_LOW]};
    assign prof[p].frac_num = {bank_q[p][REL_NUM_HIGH], bank_q[p][REL_NUM_MID],
                               bank_q[p][REL_NUM_LOW]};
    assign prof[p].frac_den = {bank_q[p][REL_DEN_HIGH], bank_q[p][REL_DEN_MID],
                               bank_q[p][REL_DEN_LOW]};
  end

  logic sel_valid;
  logic sel_idx;

  // Smallest priority code wins; a tie goes to the lower input, B before C
  always_comb begin
    sel_valid = 1'b0;
    sel_idx = 1'b0;
    for (int p = 0; p < NPROF; p++) begin
      if (prof[p].enable && (!sel_valid || prof[p].priority_level < prof[sel_idx].priority_level)) begin
        sel_valid = 1'b1;
        sel_idx = 1'(p);
      end
    end
  end

  // Registered so the loop sees one coherent profile, never a mix mid-write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      active_cfg <= '0;
      active_valid <= 1'b0;
      active_ref <= 1'b0;
      active_div_ratio <= '0;
      active_frac_enable <= 1'b0;
    end else if (clk_en) begin
      active_valid <= sel_valid;
      active_ref <= sel_idx;
      active_cfg <= sel_valid ? prof[sel_idx] : '0;
      active_div_ratio <= sel_valid ? {1'b0, prof[sel_idx].int_div_m1} + 19'h00001 : '0;
      active_frac_enable <= sel_valid && prof[sel_idx].frac_den != 24'h000000;
    end
  end

  // Status word mirrors the registered loop choice
  assign status_byte = {3'h0, active_frac_enable, active_cfg.priority_level, active_ref, active_valid};

endmodule

// >>> sim/dpr_reference_profile_regs_chk.sv
module dpr_reference_profile_regs_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire dpr_pkg::dpr_axil_req_t axi_req,
  input wire dpr_pkg::dpr_axil_rsp_t axi_rsp,
  input wire dpr_pkg::dpr_profile_t active_cfg,
  input wire logic active_valid,
  input wire logic active_ref,
  input wire logic [18:0] active_div_ratio,
  input wire logic active_frac_enable
);
  import dpr_pkg::*;
  // ************************************************************
  // Properties; one clock domain, so shared clock and disable
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Both halves of a write taken, then one running edge to land it
  sequence s_wr_taken;
    clk_en && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_wr_landed;
    s_wr_taken ##1 clk_en;
  endsequence
  property p_ratio;
    active_valid |-> active_div_ratio == {1'b0, active_cfg.int_div_m1} + 19'h1;
  endproperty
  property p_none;
    !active_valid |-> active_div_ratio == 19'h0 && active_cfg == '0 && !active_ref && !active_frac_enable;
  endproperty
  property p_frac;
    active_frac_enable == (active_cfg.frac_den != 24'h0);
  endproperty
  property p_enable;
    active_valid == active_cfg.enable;
  endproperty
  property p_rsvd;
    axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0;
  endproperty
  property p_bresp;
    s_wr_landed |=> axi_rsp.bvalid;
  endproperty
  property p_bhold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  property p_rhold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  property p_ar_block;
    axi_rsp.rvalid |-> !axi_rsp.arready;
  endproperty
  property p_reset;
    $fell(reset) |-> !active_valid && !axi_rsp.bvalid && !axi_rsp.rvalid;
  endproperty
  a_ratio: assert property (p_ratio) else $error("divide ratio is not stored value plus one");
  a_none: assert property (p_none) else $error("outputs not zero with no input enabled");
  a_frac: assert property (p_frac) else $error("fraction enable does not follow modulus");
  a_enable: assert property (p_enable) else $error("valid does not follow enable bit");
  a_rsvd: assert property (p_rsvd) else $error("upper read data bits not zero");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  a_ar_block: assert property (p_ar_block) else $error("read address taken while data pending");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind dpr_reference_profile_regs dpr_reference_profile_regs_chk u_chk (.clk_sys(clk_sys), .reset(reset),
  .clk_en(clk_en), .axi_req(axi_req), .axi_rsp(axi_rsp), .active_cfg(active_cfg), .active_valid(active_valid),
  .active_ref(active_ref), .active_div_ratio(active_div_ratio), .active_frac_enable(active_frac_enable));

// >>> sim/dpr_reference_profile_regs_bench.sv
module dpr_reference_profile_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dpr_pkg::*;
  localparam logic [15:0] B0 = {2'b00, IDX_B_PRIORITY_ENABLE, 2'b00};
  localparam logic [15:0] C0 = {2'b00, IDX_C_PRIORITY_ENABLE, 2'b00};
  localparam logic [15:0] ST0 = {2'b00, IDX_STATUS, 2'b00};
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  dpr_axil_req_t req = '0;
  dpr_axil_rsp_t rsp;
  dpr_profile_t cfg;
  logic act_valid, act_ref, frac_en;
  logic [18:0] ratio;
  int mismatches = 0;
  int total_checks = 0;
  // Free running system clock
  always #2 clk_sys = ~clk_sys;
  dpr_reference_profile_regs u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .axi_req(req),
    .axi_rsp(rsp), .active_cfg(cfg), .active_valid(act_valid), .active_ref(act_ref),
    .active_div_ratio(ratio), .active_frac_enable(frac_en));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Upper data bits are set on purpose; they must be dropped
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    req.awaddr <= a;
    req.wdata <= {24'hffffff, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    // Ready raised only once the answer shows, so the response must wait for it
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    // Read data must stand while ready is still low
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk("rdata", rsp.rdata, {24'h0, ed});
    chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
  endtask
  // Selection outputs trail the register write by one edge; three gives margin
  task automatic sel(input logic v, input logic r, input logic [18:0] er, input logic fe);
    repeat (3) @(posedge clk_sys);
    chk("active_valid", {31'h0, act_valid}, {31'h0, v});
    chk("active_ref", {31'h0, act_ref}, {31'h0, r});
    chk("div_ratio", {13'h0, ratio}, {13'h0, er});
    chk("frac_enable", {31'h0, frac_en}, {31'h0, fe});
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    for (int i = 0; i < 14; i++) rd(B0 + 16'(4 * i), 8'h00, RESP_OKAY);
    sel(1'b0, 1'b0, 19'h0, 1'b0);
  endtask
  // Distinct bytes expose byte order; reserved bits in the low nibble are written as ones
  task automatic t_fields;
    logic [7:0] m;
    // Priority register last, so the input is enabled only with a nonzero bandwidth
    for (int i = 12; i >= 0; i--) begin
      m = (4'(i) == REL_PRIO) ? 8'h07 : (4'(i) == REL_BW_TOP || 4'(i) == REL_INT_HIGH) ? 8'h03 : 8'hff;
      wr(B0 + 16'(4 * i), 8'h0f + 8'(16 * i), RESP_OKAY);
      rd(B0 + 16'(4 * i), (8'h0f + 8'(16 * i)) & m, RESP_OKAY);
    end
    sel(1'b1, 1'b0, 19'h35f50, 1'b1);
    chk("priority", {30'h0, cfg.priority_level}, 32'h3);
    chk("bw_scale", {15'h0, cfg.bw_scale}, 32'h12f1f);
    chk("margin", {31'h0, cfg.high_margin}, 32'h1);
    chk("frac_num", {8'h0, cfg.frac_num}, 32'h9f8f7f);
    chk("frac_den", {8'h0, cfg.frac_den}, 32'hcfbfaf);
    // Bandwidth drops to 1206.3 Hz in the same write, so the normal filter is allowed
    wr(B0 + 16'hc, 8'h00, RESP_OKAY);
    sel(1'b1, 1'b0, 19'h35f50, 1'b1);
    chk("margin", {31'h0, cfg.high_margin}, 32'h0);
    chk("bw_scale", {15'h0, cfg.bw_scale}, 32'h02f1f);
  endtask
  // Input C has zero divider and modulus, input B sits at priority 3
  task automatic t_prio;
    // Input C gets 409.6 Hz, kept low for its detector rate, before it is ever enabled
    wr(C0 + 16'h8, 8'h10, RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      wr(C0, {5'h0, 2'(p), 1'b1}, RESP_OKAY);
      sel(1'b1, p != 3, (p != 3) ? 19'h1 : 19'h35f50, p == 3);
      chk("bw_scale", {15'h0, cfg.bw_scale}, (p != 3) ? 32'h01000 : 32'h02f1f);
    end
    // Status shows B chosen at priority 3 with fraction on; writes to it are dropped
    rd(ST0, 8'h1d, RESP_OKAY);
    wr(ST0, 8'h00, RESP_OKAY);
    rd(ST0, 8'h1d, RESP_OKAY);
    wr(C0, 8'h06, RESP_OKAY);
    sel(1'b1, 1'b0, 19'h35f50, 1'b1);
    wr(B0, 8'h00, RESP_OKAY);
    sel(1'b0, 1'b0, 19'h0, 1'b0);
  endtask
  task automatic t_err;
    rd(B0 - 16'h4, 8'h00, RESP_SLVERR);
    rd(B0 + 16'h1, 8'h00, RESP_SLVERR);
    wr(B0 - 16'h4, 8'hff, RESP_SLVERR);
    wr(B0 + 16'h5, 8'hff, RESP_SLVERR);
    rd(B0 + 16'h4, 8'h1f, RESP_OKAY);
    // Clock enable low must refuse write address and read address requests
    @(posedge clk_sys);
    clk_en <= 1'b0;
    @(posedge clk_sys);
    chk("awready", {31'h0, rsp.awready}, 32'h0);
    chk("arready", {31'h0, rsp.arready}, 32'h0);
    clk_en <= 1'b1;
  endtask
  // Main sequence, after two cycles of reset
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_prio();
    t_err();
    stop_test();
  end
  // Watchdog; the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
endmodule
